// File: verilog/pvd_pkg.sv
// Shared constants and types for the video palette converter port
package pvd_pkg;

	localparam int PVD_ADDR_W = 16;
	localparam int PVD_IDX_W = 8;
	localparam int PVD_COMP_W = 6;
	localparam int PVD_ENTRY_W = 18;
	localparam int PVD_ENTRIES = 256;

	// Host I/O port addresses
	localparam logic [15:0] PVD_PORT_MASK = 16'h03C6;
	localparam logic [15:0] PVD_PORT_READ_PTR = 16'h03C7;
	localparam logic [15:0] PVD_PORT_STATE = 16'h03C7;
	localparam logic [15:0] PVD_PORT_WRITE_PTR = 16'h03C8;
	localparam logic [15:0] PVD_PORT_DATA = 16'h03C9;

	// Entry field positions
	localparam int PVD_RED_LSB = 12;
	localparam int PVD_GREEN_LSB = 6;
	localparam int PVD_BLUE_LSB = 0;

	// Reset and fixed values
	localparam logic [7:0] PVD_MASK_VALUE = 8'hFF;
	localparam logic [1:0] PVD_STATE_READ = 2'h0;
	localparam logic [1:0] PVD_STATE_WRITE = 2'h3;
	localparam logic [7:0] PVD_PTR_RESET = 8'h00;
	localparam logic [2:0] PVD_CLK_SRC_ADAPTER = 3'h2;

	// Timing
	localparam int PVD_PIPE_CYCLES = 3;
	localparam int PVD_HOST_SPACING_DOTS = 6;

	typedef enum logic {PVD_CYC_READ, PVD_CYC_WRITE} pvd_cyc_e;
	typedef enum logic [1:0] {PVD_PH_RED, PVD_PH_GREEN, PVD_PH_BLUE} pvd_phase_e;

endpackage : pvd_pkg

// File: verilog/pvd_palette_ram.sv
// Palette store: host write on the core clock, unclocked host read, registered lookup on the pixel clock
`timescale 1ns/100ps
module pvd_palette_ram
	import pvd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_wr_en,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_wr_addr,
	input wire logic [pvd_pkg::PVD_ENTRY_W-1:0] i_wr_data,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_core_raddr,
	output logic [pvd_pkg::PVD_ENTRY_W-1:0] o_core_rdata,
	input wire logic i_pixel_clock_line,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_pix_raddr,
	output logic [pvd_pkg::PVD_ENTRY_W-1:0] o_pix_rdata
);
	import pvd_pkg::*;

	logic [PVD_ENTRY_W-1:0] mem [0:PVD_ENTRIES-1];

	always_ff @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	assign o_core_rdata = mem[i_core_raddr];

	always_ff @(posedge i_pixel_clock_line) begin
		o_pix_rdata <= mem[i_pix_raddr];
	end

endmodule : pvd_palette_ram

// File: verilog/pvd_pixel_pipe.sv
// Pixel-clock pipeline: source select, capture, lookup, blanking
`timescale 1ns/100ps
module pvd_pixel_pipe
	import pvd_pkg::*;
(
	input wire logic i_pixel_clock_line,
	input wire logic i_nrst,
	input wire logic i_external_sync_select,
	input wire logic i_external_pixel_select,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_board_pixel_index,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_adapter_pixel_index,
	input wire logic i_board_blank_n,
	input wire logic i_adapter_blank_n,
	input wire logic i_board_hsync,
	input wire logic i_adapter_hsync,
	input wire logic i_board_vsync,
	input wire logic i_adapter_vsync,
	output logic [pvd_pkg::PVD_IDX_W-1:0] o_ram_addr,
	input wire logic [pvd_pkg::PVD_ENTRY_W-1:0] i_ram_data,
	output logic [pvd_pkg::PVD_COMP_W-1:0] o_red,
	output logic [pvd_pkg::PVD_COMP_W-1:0] o_green,
	output logic [pvd_pkg::PVD_COMP_W-1:0] o_blue,
	output logic o_hsync,
	output logic o_vsync
);
	import pvd_pkg::*;

	logic rst_q1;
	logic pix_nrst;
	logic [1:0] sel_raw;
	logic [1:0] sel_q1;
	logic [1:0] sel_q2;
	logic [1:0] sel_q3;
	logic [1:0] sel;
	logic [PVD_IDX_W-1:0] idx_s1;
	logic [2:0] ctl_s1;
	logic [2:0] ctl_s2;
	logic [2:0] ctl_s3;
	logic [PVD_ENTRY_W-1:0] data_s3;
	wire [PVD_IDX_W-1:0] idx_in;
	wire blank_in_n;
	wire hsync_in;
	wire vsync_in;

	////////////////////////////////////////////////////////////////////////
	// Reset into pixel domain, select lines through three stages
	always_ff @(posedge i_pixel_clock_line) begin
		rst_q1 <= i_nrst;
		pix_nrst <= rst_q1;
	end

	assign sel_raw = {i_external_pixel_select, i_external_sync_select};

	generate
		for (genvar g = 0; g < 2; g++) begin : g_sel
			always_ff @(posedge i_pixel_clock_line) begin
				sel_q1[g] <= sel_raw[g];
				sel_q2[g] <= sel_q1[g];
				sel_q3[g] <= sel_q2[g];
				if (!pix_nrst) begin
					sel[g] <= 1'b1;
				end else if (sel_q2[g] == sel_q3[g]) begin
					sel[g] <= sel_q2[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Source selection
	assign idx_in = sel[1] ? i_board_pixel_index : i_adapter_pixel_index;
	assign blank_in_n = sel[0] ? i_board_blank_n : i_adapter_blank_n;
	assign hsync_in = sel[0] ? i_board_hsync : i_adapter_hsync;
	assign vsync_in = sel[0] ? i_board_vsync : i_adapter_vsync;
	assign o_ram_addr = idx_s1 & PVD_MASK_VALUE;

	////////////////////////////////////////////////////////////////////////
	// Capture, lookup, output: output follows capture by three edges
	always_ff @(posedge i_pixel_clock_line) begin
		idx_s1 <= idx_in;
		ctl_s1 <= {blank_in_n, hsync_in, vsync_in};
		ctl_s2 <= ctl_s1;
		ctl_s3 <= ctl_s2;
		data_s3 <= i_ram_data;
	end

	always_ff @(posedge i_pixel_clock_line) begin
		if (!pix_nrst || !ctl_s3[2]) begin
			o_red <= '0;
			o_green <= '0;
			o_blue <= '0;
		end else begin
			o_red <= data_s3[PVD_RED_LSB +: PVD_COMP_W];
			o_green <= data_s3[PVD_GREEN_LSB +: PVD_COMP_W];
			o_blue <= data_s3[PVD_BLUE_LSB +: PVD_COMP_W];
		end
		o_hsync <= pix_nrst & ctl_s3[1];
		o_vsync <= pix_nrst & ctl_s3[0];
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_blank_taken;
		pix_nrst && !blank_in_n;
	endsequence

	AST_BLANK_LATENCY: assert property (@(posedge i_pixel_clock_line) disable iff (!pix_nrst)
		s_blank_taken |-> ##4 (o_red == '0 && o_green == '0 && o_blue == '0))
		else $error("blanking did not zero outputs three edges after capture");

	AST_PIXEL_SOURCE: assert property (@(posedge i_pixel_clock_line) disable iff (!pix_nrst)
		sel[1] |=> idx_s1 == $past(i_board_pixel_index))
		else $error("board pixel index not captured while board selected");

endmodule : pvd_pixel_pipe

// File: verilog/pvd_palette_dac.sv
// Palette converter port: host register port, palette store, pixel pipeline
//
// What this block does
// - Palette holds 256 entries of 18 bits, red, green, blue six each.
// - Each colour output comes from one six-bit component of the entry.
// - Pixel index and blanking are captured on each pixel clock rising edge.
// - Outputs reflect captured index and blanking three pixel clocks later.
// - Active blanking forces all colour outputs to zero regardless of palette.
// - An eight-bit pointer selects the entry reached through the data port.
// - Writing the pointer at 03C8 loads it and starts a write cycle.
// - Host writes red, green, blue bytes to 03C9; low six bits form the entry.
// - Writing pointer at 03C7 starts a read cycle returning red, green, blue bytes.
// - After each full three-byte transfer the pointer steps to the next entry.
// - Pointer write mid-cycle drops the partial cycle, restarts at new pointer.
// - State register bits 1:0 read 00 after read setup, 11 after write setup.
// - Reading pointer or state register never disturbs a cycle in progress.
// - Sync select high: board drives blanking and syncs; low: adapter does.
// - Pixel select high: board drives the pixel index; low: adapter does.
// - Clock select low needs clock source 010; high forbids that code.
// - Blanking input is active low; low drives colour outputs to zero.
`timescale 1ns/100ps
module pvd_palette_dac
	import pvd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [pvd_pkg::PVD_ADDR_W-1:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	input wire logic [2:0] i_clock_source_code,
	input wire logic i_external_clock_select,
	output logic o_clock_source_fault,
	input wire logic i_pixel_clock_line,
	input wire logic i_external_sync_select,
	input wire logic i_external_pixel_select,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_board_pixel_index,
	input wire logic [pvd_pkg::PVD_IDX_W-1:0] i_adapter_pixel_index,
	input wire logic i_board_blank_n,
	input wire logic i_adapter_blank_n,
	input wire logic i_board_hsync,
	input wire logic i_adapter_hsync,
	input wire logic i_board_vsync,
	input wire logic i_adapter_vsync,
	output logic [pvd_pkg::PVD_COMP_W-1:0] o_red,
	output logic [pvd_pkg::PVD_COMP_W-1:0] o_green,
	output logic [pvd_pkg::PVD_COMP_W-1:0] o_blue,
	output logic o_hsync,
	output logic o_vsync
);
	import pvd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [PVD_IDX_W-1:0] ptr;
	logic [PVD_IDX_W-1:0] next_ptr;
	pvd_cyc_e cyc;
	pvd_cyc_e next_cyc;
	pvd_phase_e phase;
	pvd_phase_e next_phase;
	logic [PVD_COMP_W-1:0] red_hold;
	logic [PVD_COMP_W-1:0] green_hold;
	logic [PVD_ENTRY_W-1:0] rd_buf;
	logic fetch_pend;
	logic ecs_q1;
	logic ecs_q2;
	logic ecs_q3;
	logic ecs;
	logic [PVD_ENTRY_W-1:0] core_rdata;
	logic [PVD_IDX_W-1:0] pix_addr;
	logic [PVD_ENTRY_W-1:0] pix_data;

	wire hit_mask;
	wire hit_state;
	wire hit_wptr;
	wire hit_data;
	wire wr_rptr;
	wire wr_wptr;
	wire setup;
	wire rd_mask;
	wire rd_state;
	wire rd_wptr;
	wire data_wr_ok;
	wire data_rd_ok;
	wire data_step;
	wire last_byte;
	wire commit;
	wire read_done;
	wire [1:0] state_bits;
	wire [PVD_COMP_W-1:0] rd_comp;
	wire [7:0] next_rdata;
	wire [PVD_ENTRY_W-1:0] ram_wdata;
	wire src_is_adapter;

	////////////////////////////////////////////////////////////////////////
	// Address decode
	assign hit_mask = (i_io_addr == PVD_PORT_MASK);
	assign hit_state = (i_io_addr == PVD_PORT_STATE);
	assign hit_wptr = (i_io_addr == PVD_PORT_WRITE_PTR);
	assign hit_data = (i_io_addr == PVD_PORT_DATA);

	assign wr_rptr = i_io_wr && (i_io_addr == PVD_PORT_READ_PTR);
	assign wr_wptr = i_io_wr && hit_wptr;
	assign setup = wr_rptr || wr_wptr;

	assign rd_mask = i_io_rd && hit_mask;
	assign rd_state = i_io_rd && hit_state;
	assign rd_wptr = i_io_rd && hit_wptr;

	// Wrong-direction data accesses are dropped
	assign data_wr_ok = i_io_wr && hit_data && (cyc == PVD_CYC_WRITE);
	assign data_rd_ok = i_io_rd && hit_data && (cyc == PVD_CYC_READ);
	assign data_step = data_wr_ok || data_rd_ok;

	assign last_byte = (phase == PVD_PH_BLUE);
	assign commit = data_wr_ok && last_byte;
	assign read_done = data_rd_ok && last_byte;

	////////////////////////////////////////////////////////////////////////
	// Pointer, cycle type and byte phase
	assign next_cyc = wr_rptr ? PVD_CYC_READ : (wr_wptr ? PVD_CYC_WRITE : cyc);

	always_comb begin
		if (setup) begin
			next_ptr = i_io_wdata;
		end else if (commit || read_done) begin
			next_ptr = ptr + 8'h01;
		end else begin
			next_ptr = ptr;
		end
	end

	always_comb begin
		next_phase = phase;
		if (setup) begin
			next_phase = PVD_PH_RED;
		end else if (data_step) begin
			unique case (phase)
				PVD_PH_RED: begin
					next_phase = PVD_PH_GREEN;
				end
				PVD_PH_GREEN: begin
					next_phase = PVD_PH_BLUE;
				end
				PVD_PH_BLUE: begin
					next_phase = PVD_PH_RED;
				end
				default: begin
					next_phase = PVD_PH_RED;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			ptr <= PVD_PTR_RESET;
			cyc <= PVD_CYC_READ;
			phase <= PVD_PH_RED;
		end else begin
			ptr <= next_ptr;
			cyc <= next_cyc;
			phase <= next_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write path: hold red and green, commit on blue
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			red_hold <= '0;
			green_hold <= '0;
		end else if (data_wr_ok && phase == PVD_PH_RED) begin
			red_hold <= i_io_wdata[PVD_COMP_W-1:0];
		end else if (data_wr_ok && phase == PVD_PH_GREEN) begin
			green_hold <= i_io_wdata[PVD_COMP_W-1:0];
		end
	end

	assign ram_wdata = {red_hold, green_hold, i_io_wdata[PVD_COMP_W-1:0]};

	////////////////////////////////////////////////////////////////////////
	// Read path: prefetch entry after read pointer setup and after each finished read triple
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			fetch_pend <= 1'b0;
			rd_buf <= '0;
		end else begin
			fetch_pend <= wr_rptr || read_done;
			if (fetch_pend) begin
				rd_buf <= core_rdata;
			end
		end
	end

	assign rd_comp = (phase == PVD_PH_RED) ? rd_buf[PVD_RED_LSB +: PVD_COMP_W] :
		(phase == PVD_PH_GREEN) ? rd_buf[PVD_GREEN_LSB +: PVD_COMP_W] :
		rd_buf[PVD_BLUE_LSB +: PVD_COMP_W];

	assign state_bits = (cyc == PVD_CYC_WRITE) ? PVD_STATE_WRITE : PVD_STATE_READ;

	////////////////////////////////////////////////////////////////////////
	// Read data mux; side-effect free for mask, state and pointer
	assign next_rdata = rd_mask ? PVD_MASK_VALUE :
		rd_state ? {6'h00, state_bits} :
		rd_wptr ? ptr :
		data_rd_ok ? {2'h0, rd_comp} :
		8'h00;

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			o_io_rdata <= 8'h00;
		end else if (i_io_rd) begin
			o_io_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock source check against the external clock select pin
	always_ff @(posedge i_core_clk) begin
		ecs_q1 <= i_external_clock_select;
		ecs_q2 <= ecs_q1;
		ecs_q3 <= ecs_q2;
	end

	assign src_is_adapter = (i_clock_source_code == PVD_CLK_SRC_ADAPTER);

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			ecs <= 1'b1;
			o_clock_source_fault <= 1'b0;
		end else begin
			if (ecs_q2 == ecs_q3) begin
				ecs <= ecs_q2;
			end
			o_clock_source_fault <= ecs ? src_is_adapter : !src_is_adapter;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Palette store and pixel pipeline
	pvd_palette_ram u_ram (
		.i_core_clk(i_core_clk),
		.i_wr_en(commit),
		.i_wr_addr(ptr),
		.i_wr_data(ram_wdata),
		.i_core_raddr(ptr),
		.o_core_rdata(core_rdata),
		.i_pixel_clock_line(i_pixel_clock_line),
		.i_pix_raddr(pix_addr),
		.o_pix_rdata(pix_data)
	);

	pvd_pixel_pipe u_pipe (
		.i_pixel_clock_line(i_pixel_clock_line),
		.i_nrst(i_nrst),
		.i_external_sync_select(i_external_sync_select),
		.i_external_pixel_select(i_external_pixel_select),
		.i_board_pixel_index(i_board_pixel_index),
		.i_adapter_pixel_index(i_adapter_pixel_index),
		.i_board_blank_n(i_board_blank_n),
		.i_adapter_blank_n(i_adapter_blank_n),
		.i_board_hsync(i_board_hsync),
		.i_adapter_hsync(i_adapter_hsync),
		.i_board_vsync(i_board_vsync),
		.i_adapter_vsync(i_adapter_vsync),
		.o_ram_addr(pix_addr),
		.i_ram_data(pix_data),
		.o_red(o_red),
		.o_green(o_green),
		.o_blue(o_blue),
		.o_hsync(o_hsync),
		.o_vsync(o_vsync)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks on the host side
	default clocking cb_core @(posedge i_core_clk);
	endclocking

	default disable iff (!i_nrst);

	sequence s_read_setup;
		wr_rptr ##1 !i_io_wr && !i_io_rd;
	endsequence

	sequence s_write_setup;
		wr_wptr;
	endsequence

	AST_WRITE_SETUP: assert property (
		s_write_setup |=> (ptr == $past(i_io_wdata) && cyc == PVD_CYC_WRITE && phase == PVD_PH_RED))
		else $error("write pointer setup did not load pointer and write cycle");

	AST_READ_FETCH: assert property (
		s_read_setup |=> (rd_buf == $past(core_rdata) && cyc == PVD_CYC_READ && phase == PVD_PH_RED))
		else $error("read setup did not prefetch the addressed entry");

	AST_STEP_AFTER_TRIPLE: assert property (
		(commit || read_done) |=> (ptr == $past(ptr) + 8'h01 && phase == PVD_PH_RED))
		else $error("pointer did not step after a full transfer");

	AST_COMMIT_ENTRY: assert property (
		commit |-> (cyc == PVD_CYC_WRITE && ram_wdata[PVD_BLUE_LSB +: PVD_COMP_W] == i_io_wdata[5:0]
		&& ram_wdata[PVD_RED_LSB +: PVD_COMP_W] == red_hold))
		else $error("entry commit does not match held bytes");

	AST_GREEN_READ: assert property (
		(data_rd_ok && phase == PVD_PH_GREEN) |=> (o_io_rdata == {2'h0, $past(rd_buf[11:6])}))
		else $error("green read byte wrong");

	AST_RED_READ: assert property (
		(data_rd_ok && phase == PVD_PH_RED) |=> (o_io_rdata == {2'h0, $past(rd_buf[PVD_RED_LSB +: PVD_COMP_W])}))
		else $error("red read byte wrong");

	AST_REFETCH_NEXT: assert property (
		read_done ##1 1'b1 |=> (rd_buf == $past(core_rdata)))
		else $error("next entry not fetched after a finished read triple");

	AST_STATE_BITS: assert property (
		rd_state |=> (o_io_rdata[7:2] == 6'h00 && o_io_rdata[1] == o_io_rdata[0]
		&& o_io_rdata[0] == (cyc == PVD_CYC_WRITE)))
		else $error("state register does not show last cycle type");

	AST_PEEK_HARMLESS: assert property (
		(rd_state || rd_wptr) |=> (ptr == $past(ptr) && phase == $past(phase) && cyc == $past(cyc)))
		else $error("pointer or state read disturbed the cycle");

	AST_WRONG_DIR_IGNORED: assert property (
		(i_io_wr && hit_data && cyc == PVD_CYC_READ) |=> (ptr == $past(ptr) && phase == $past(phase)))
		else $error("data write in read cycle changed state");

	AST_CLOCK_SOURCE: assert property (
		(ecs && src_is_adapter) [*2] |-> o_clock_source_fault)
		else $error("forbidden clock source not flagged");

endmodule : pvd_palette_dac

// File: sim/pvd_pixel_source.sv
// Pixel source model: index, blanking and syncs driven on the pixel clock
`timescale 1ns/100ps
module pvd_pixel_source #(
	parameter logic [31:0] SEED = 32'h0000004F
) (
	input wire logic i_clk,
	output logic [7:0] o_index,
	output logic o_blank_n,
	output logic o_hsync,
	output logic o_vsync
);
	logic [31:0] s = SEED;
	initial begin
		o_index = 8'h00;
		o_blank_n = 1'h0;
		o_hsync = 1'h0;
		o_vsync = 1'h0;
	end
	// New values just after each rising edge, held a full period
	always @(posedge i_clk) begin
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		o_index <= {5'h00, s[2:0]};
		o_blank_n <= s[4:3] != 2'h0;
		o_hsync <= s[5];
		o_vsync <= s[6];
	end
endmodule : pvd_pixel_source

// File: sim/pvd_palette_dac_test.sv
// Self-checking bench for the palette converter port
`timescale 1ns/100ps
module pvd_palette_dac_test;
	import pvd_pkg::*;
	logic i_core_clk = 1'h0;
	logic pclk = 1'h0;
	logic i_nrst = 1'h0;
	logic [15:0] i_io_addr = 16'h0000;
	logic i_io_wr = 1'h0;
	logic i_io_rd = 1'h0;
	logic [7:0] i_io_wdata = 8'h00;
	logic [7:0] o_io_rdata;
	logic [2:0] code = 3'h0;
	logic clk_sel = 1'h1;
	logic fault;
	logic sync_sel = 1'h1;
	logic pix_sel = 1'h1;
	logic [7:0] b_idx, a_idx, pidx, b;
	logic b_bl, a_bl, b_hs, a_hs, b_vs, a_vs, pbl;
	logic [5:0] o_red, o_green, o_blue;
	logic o_hsync, o_vsync;
	int n_errors = 0;
	int checks_done = 0;
	logic [31:0] rs = 32'h0000004F;
	logic [7:0] hq[$];
	logic [19:0] pq[$];
	logic [17:0] pal[8];
	logic rd_seen = 1'h0;
	logic pix_on = 1'h0;

	always #2 i_core_clk = ~i_core_clk;
	always #32 pclk = ~pclk;

	pvd_palette_dac dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
		.i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_clock_source_code(code),
		.i_external_clock_select(clk_sel), .o_clock_source_fault(fault), .i_pixel_clock_line(pclk),
		.i_external_sync_select(sync_sel), .i_external_pixel_select(pix_sel), .i_board_pixel_index(b_idx),
		.i_adapter_pixel_index(a_idx), .i_board_blank_n(b_bl), .i_adapter_blank_n(a_bl),
		.i_board_hsync(b_hs), .i_adapter_hsync(a_hs), .i_board_vsync(b_vs), .i_adapter_vsync(a_vs),
		.o_red(o_red), .o_green(o_green), .o_blue(o_blue), .o_hsync(o_hsync), .o_vsync(o_vsync));
	pvd_pixel_source #(.SEED(32'h0000004F)) board (.i_clk(pclk), .o_index(b_idx), .o_blank_n(b_bl),
		.o_hsync(b_hs), .o_vsync(b_vs));
	pvd_pixel_source #(.SEED(32'h0000A51D)) adapter (.i_clk(pclk), .o_index(a_idx), .o_blank_n(a_bl),
		.o_hsync(a_hs), .o_vsync(a_vs));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction : xs

	task chk(input logic [19:0] got, input logic [19:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task end_of_test();
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// One host access, spaced by seven pixel clocks
	task acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
		repeat (7) @(posedge pclk);
		@(posedge i_core_clk);
		i_io_addr <= a;
		i_io_wdata <= d;
		i_io_wr <= wr;
		i_io_rd <= ~wr;
		@(posedge i_core_clk);
		i_io_wr <= 1'h0;
		i_io_rd <= 1'h0;
	endtask : acc

	task rd(input logic [15:0] a, input logic [7:0] e);
		hq.push_back(e);
		acc(1'h0, a, 8'h00);
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	always @(posedge i_core_clk) begin
		if (rd_seen) begin
			if (hq.size() == 0) begin
				chk(20'h00001, 20'h00000, "read with no note");
			end else begin
				chk({12'h000, o_io_rdata}, {12'h000, hq.pop_front()}, "host read");
			end
		end
		rd_seen <= i_io_rd;
	end

	// Capture note at each edge, compared four edges later
	always @(posedge pclk) begin
		if (!pix_on) begin
			pq.delete();
		end else begin
			pidx = pix_sel ? b_idx : a_idx;
			pbl = sync_sel ? b_bl : a_bl;
			pq.push_back({pbl ? pal[pidx[2:0]] : 18'h00000, sync_sel ? {b_hs, b_vs} : {a_hs, a_vs}});
			if (pq.size() == 5) begin
				chk({o_red, o_green, o_blue, o_hsync, o_vsync}, pq.pop_front(), "pixel");
			end
		end
	end

	initial begin
		#300000;
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge pclk);
		@(posedge i_core_clk);
		i_nrst <= 1'h1;
		rd(PVD_PORT_STATE, 8'h00);
		rd(PVD_PORT_WRITE_PTR, PVD_PTR_RESET);
		rd(PVD_PORT_MASK, PVD_MASK_VALUE);
		acc(1'h1, PVD_PORT_MASK, 8'h00);
		rd(PVD_PORT_MASK, PVD_MASK_VALUE);
		rd(16'h03C5, 8'h00);
		$display("test reset and fixed values done");
		acc(1'h1, PVD_PORT_WRITE_PTR, 8'h00);
		rd(PVD_PORT_STATE, 8'h03);
		for (int i = 0; i < 8; i++) begin
			for (int c = 0; c < 3; c++) begin
				b = xs();
				pal[i][17 - 6 * c -: 6] = b[5:0];
				acc(1'h1, PVD_PORT_DATA, b);
				rd(PVD_PORT_WRITE_PTR, (c == 2) ? 8'(i + 1) : 8'(i));
			end
		end
		$display("test palette load done");
		acc(1'h1, PVD_PORT_WRITE_PTR, 8'h05);
		acc(1'h1, PVD_PORT_DATA, 8'h3F);
		acc(1'h1, PVD_PORT_WRITE_PTR, 8'h06);
		for (int c = 0; c < 3; c++) begin
			b = xs();
			pal[6][17 - 6 * c -: 6] = b[5:0];
			acc(1'h1, PVD_PORT_DATA, b);
		end
		$display("test abandoned write done");
		acc(1'h1, PVD_PORT_READ_PTR, 8'h00);
		rd(PVD_PORT_STATE, 8'h00);
		for (int i = 0; i < 8; i++) begin
			for (int c = 0; c < 3; c++) begin
				rd(PVD_PORT_DATA, {2'h0, pal[i][17 - 6 * c -: 6]});
				if (c == 0) begin
					rd(PVD_PORT_STATE, 8'h00);
				end
			end
		end
		rd(PVD_PORT_WRITE_PTR, 8'h08);
		acc(1'h1, PVD_PORT_READ_PTR, 8'h02);
		rd(PVD_PORT_DATA, {2'h0, pal[2][17:12]});
		acc(1'h1, PVD_PORT_READ_PTR, 8'h04);
		rd(PVD_PORT_DATA, {2'h0, pal[4][17:12]});
		rd(PVD_PORT_DATA, {2'h0, pal[4][11:6]});
		$display("test palette read done");
		for (int k = 0; k < 16; k++) begin
			@(posedge i_core_clk);
			code <= k[2:0];
			clk_sel <= k[3];
			repeat (8) @(posedge i_core_clk);
			chk({19'h00000, fault}, {19'h00000, (code == PVD_CLK_SRC_ADAPTER) == clk_sel}, "clock source");
		end
		$display("test clock source done");
		for (int m = 0; m < 4; m++) begin
			@(posedge i_core_clk);
			pix_on <= 1'h0;
			sync_sel <= m[0];
			pix_sel <= m[1];
			clk_sel <= m[1];
			code <= m[1] ? 3'h0 : PVD_CLK_SRC_ADAPTER;
			repeat (8) @(posedge pclk);
			@(posedge i_core_clk);
			pix_on <= 1'h1;
			repeat (60) @(posedge pclk);
			$display("test pixel mode %0d done", m);
		end
		@(posedge i_core_clk);
		pix_on <= 1'h0;
		repeat (4) @(posedge i_core_clk);
		end_of_test();
	end
endmodule : pvd_palette_dac_test
